/* File: pssi_master.sv */
// Behavioural two-wire bus master standing in for the application processor.
// Assumes a pull-up on the data wire and the 50 MHz bench clock for pacing.
`timescale 1ns/1ps
module pssi_master (
   input  wire logic i_mclk,
   input  wire logic i_sda,
   output logic      o_scl,
   output logic      o_sda_oe
);
   initial begin
      o_scl    = 1'b1;
      o_sda_oe = 1'b0;
   end

   task automatic w(int n);
      repeat (n) @(posedge i_mclk);
   endtask : w

   // Waits first so a slave still holding its acknowledge has let go
   task automatic start();
      w(4);
      o_sda_oe <= 1'b0;
      w(4);
      o_scl <= 1'b1;
      w(4);
      o_sda_oe <= 1'b1;
      w(4);
      o_scl <= 1'b0;
   endtask : start

   // Clock period of eight mclk, 160 ns, four high and four low
   task automatic one_bit(input logic b, output logic s);
      w(2);
      o_sda_oe <= ~b;
      w(2);
      o_scl <= 1'b1;
      w(4);
      s = i_sda;
      o_scl <= 1'b0;
   endtask : one_bit

   // Ack slot: 1 releases the line, 0 acknowledges a read byte
   task automatic xfer(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         one_bit(tx[i], rx[i]);
      end
      one_bit(ack_bit, ack);
   endtask : xfer

   task automatic stop();
      w(2);
      o_sda_oe <= 1'b1;
      w(2);
      o_scl <= 1'b1;
      w(4);
      o_sda_oe <= 1'b0;
      w(4);
   endtask : stop
endmodule : pssi_master

/* File: pssi_pkg.sv */
// Constants, types and states for the serial status and interrupt port.
// Assumes one 50 MHz clock. All pins reach the core through two-flop synchronisers.
//
// Overview of operation
// RULE_01: Serial slave accepts standard and fast mode transfers up to 400 kHz.
// RULE_02: Seven-bit slave address: upper six bits 100100, lowest bit from select pin.
// RULE_03: Reading an unimplemented register index returns FFh.
// RULE_04: Data line changes only while clock low, except start and stop.
// RULE_05: Device pulls data low for the whole ack clock after each received byte.
// RULE_06: Master supplies a ninth clock per byte for the acknowledge.
// RULE_07: Master leaves the ack slot of its last read byte undriven.
// RULE_08: After master not-acknowledge the device releases the data line.
// RULE_09: Charge status bits 7 and 6 show bus-powered and wall source valid.
// RULE_10: Charge bits: 5 thermal, 4 termination, 3-1 timer expiry, 0 battery temperature.
// RULE_11: Writing charge status bits 1-4 clear restarts the charger algorithm.
// RULE_12: Writes to charge status bit 0 and bits 5-7 have no effect.
// RULE_13: Any unmasked set charge status bit drives interrupt low.
// RULE_14: Regulator bits: 7 pushbutton, 6 cover pin low, 5 undervoltage, 4 reads 0.
// RULE_15: Regulator bits 3-0 flag rails out of regulation; disabled linear regulators read 0.
// RULE_16: Core good flag also reads 1 when low-power select set in low-power mode.
// RULE_17: Rising regulator status bit drives interrupt low unless masked.
// RULE_18: Charge mask resets to FFh; set bit blocks matching status bit.
// RULE_19: Regulator mask resets to FFh; set bit blocks matching status bit.
// RULE_20: Set ack bit removes its status from interrupt; output high when nothing pending.
// RULE_21: Ack bits clear when their status clears; ack registers read-only, reset 00h.
// RULE_22: Reading a set status bit sets its ack bit automatically.
// RULE_23: Charge bits 5,0 edge-set, clear when source low and acked; others follow level.
// RULE_24: Regulator bits 7-5 edge-set, clear when source low and acked; 3-0 follow level.
// RULE_25: Write is address, index, data; read sets index first then returns byte.
// RULE_26: Status byte is latched at read start so new events are not lost.
package pssi_pkg;

   localparam logic [5:0] ADDR_UPPER     = 6'h24;
   localparam int         SCL_MAX_KHZ    = 400;
   localparam int         MCLK_KHZ       = 50000;
   localparam int         SCL_HALF_CYC   = MCLK_KHZ / (2 * SCL_MAX_KHZ);

   localparam logic [7:0] IDX_CHG_STATUS = 8'h01;
   localparam logic [7:0] IDX_REG_STATUS = 8'h02;
   localparam logic [7:0] IDX_CHG_MASK   = 8'h03;
   localparam logic [7:0] IDX_REG_MASK   = 8'h04;
   localparam logic [7:0] IDX_CHG_ACK    = 8'h05;
   localparam logic [7:0] IDX_REG_ACK    = 8'h06;
   localparam logic [7:0] UNMAPPED_BYTE  = 8'hff;

   localparam logic [7:0] STATUS_RESET   = 8'h00;
   localparam logic [7:0] MASK_RESET     = 8'hff;
   localparam logic [7:0] ACK_RESET      = 8'h00;

   localparam logic [7:0] CHG_EDGE_BITS  = 8'h21;
   localparam logic [7:0] CHG_LEVEL_BITS = 8'hde;
   localparam logic [7:0] CHG_WR_BITS    = 8'h1e;
   localparam logic [7:0] REG_EDGE_BITS  = 8'he0;

   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_RX     = 3'b001,
      ST_RX_ACK = 3'b010,
      ST_TX     = 3'b011,
      ST_TX_ACK = 3'b100
   } pssi_state_t;

   typedef enum logic [1:0] {
      K_ADDR  = 2'b00,
      K_INDEX = 2'b01,
      K_DATA  = 2'b10
   } pssi_kind_t;

   // Raw condition sources from the analogue side
   typedef struct packed {
      logic [7:0] chg;
      logic [7:0] regl;
      logic       first_linear_regulator_en;
      logic       second_linear_regulator_en;
      logic       core_lp_sel;
      logic       low_power;
   } pssi_src_t;

   typedef struct packed {
      logic scl;
      logic sda;
      logic addr_lsb;
   } pssi_pins_t;

endpackage : pssi_pkg

/* File: pssi_status_irq.sv */
// Two-wire serial slave with charge and regulator status, masks, acks and interrupt.
// Assumes open-drain pins are resolved outside; the master owns the serial clock.
`timescale 1ns/1ps
module pssi_status_irq
   import pssi_pkg::*;
(
   input  wire logic      i_mclk,
   input  wire logic      i_srst,
   input  wire logic      i_scl,
   input  wire logic      i_sda,
   input  wire logic      i_addr_lsb_select,
   input  wire pssi_src_t i_src,
   output logic           o_sda_out,
   output logic           o_sda_oe,
   output logic           o_irq_n,
   output logic           o_charger_restart
);

   // ************************************************************
   // Pin synchronisers
   // ************************************************************
   pssi_pins_t  pin_lvl;
   pssi_pins_t  pin_rise;
   pssi_pins_t  pin_fall;
   pssi_src_t   src;
   pssi_src_t   src_rise;

   pssi_sync #(.W($bits(pssi_pins_t))) u_pin_sync (
      .i_mclk  (i_mclk),
      .i_srst  (i_srst),
      .i_async ({i_scl, i_sda, i_addr_lsb_select}),
      .o_level (pin_lvl),
      .o_rise  (pin_rise),
      .o_fall  (pin_fall)
   );

   pssi_sync #(.W($bits(pssi_src_t))) u_src_sync (
      .i_mclk  (i_mclk),
      .i_srst  (i_srst),
      .i_async (i_src),
      .o_level (src),
      .o_rise  (src_rise),
      .o_fall  ()
   );

   // ************************************************************
   // Registers
   // ************************************************************
   logic [7:0]  charge_status;
   logic [7:0]  regulator_status;
   logic [7:0]  charge_irq_mask;
   logic [7:0]  regulator_irq_mask;
   logic [7:0]  charge_irq_ack;
   logic [7:0]  regulator_irq_ack;

   pssi_state_t st;
   pssi_kind_t  kind;
   logic [3:0]  bit_cnt;
   logic [7:0]  shreg;
   logic [7:0]  idx;
   logic        rw;
   logic        nack_q;
   logic        sda_oe;

   logic        scl_rise;
   logic        scl_fall;
   logic        start_det;
   logic        stop_det;
   logic        byte_done;
   logic        addr_hit;
   logic        load_tx;
   logic        wr_stb;
   logic [7:0]  next_charge_status;
   logic [7:0]  next_regulator_status;
   logic [7:0]  reg_level;
   logic [7:0]  rd_set_chg;
   logic [7:0]  rd_set_reg;

   function automatic logic [7:0] rd_byte(input logic [7:0] i);
      case (i)
         IDX_CHG_STATUS: rd_byte = charge_status;
         IDX_REG_STATUS: rd_byte = regulator_status;
         IDX_CHG_MASK:   rd_byte = charge_irq_mask;
         IDX_REG_MASK:   rd_byte = regulator_irq_mask;
         IDX_CHG_ACK:    rd_byte = charge_irq_ack;
         IDX_REG_ACK:    rd_byte = regulator_irq_ack;
         default:        rd_byte = UNMAPPED_BYTE;   // RULE_03
      endcase
   endfunction : rd_byte

   // ************************************************************
   // Serial bit engine
   // ************************************************************
   // Edges sampled at 50 MHz leave over 60 cycles per half bit at 400 kHz
   assign scl_rise  = pin_rise.scl;                                      // RULE_01
   assign scl_fall  = pin_fall.scl;
   assign start_det = pin_fall.sda & pin_lvl.scl;
   assign stop_det  = pin_rise.sda & pin_lvl.scl;
   assign byte_done = (st == ST_RX) && scl_fall && (bit_cnt == 4'h8);
   assign addr_hit  = (shreg[7:1] == {ADDR_UPPER, pin_lvl.addr_lsb});   // RULE_02
   assign wr_stb    = byte_done && (kind == K_DATA);                     // RULE_25
   // Status byte is captured into the shifter at the ack clock fall after the read address and after each master ack
   assign load_tx   = ((st == ST_RX_ACK) && scl_fall && rw && (kind == K_ADDR))
                   || ((st == ST_TX_ACK) && scl_fall && !nack_q);        // RULE_26

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         st      <= ST_IDLE;
         kind    <= K_ADDR;
         bit_cnt <= 4'h0;
         shreg   <= 8'h00;
         idx     <= 8'h00;
         rw      <= 1'b0;
         nack_q  <= 1'b1;
         sda_oe  <= 1'b0;
      end else if (start_det) begin
         st      <= ST_RX;
         kind    <= K_ADDR;
         bit_cnt <= 4'h0;
         sda_oe  <= 1'b0;
      end else if (stop_det) begin
         st      <= ST_IDLE;
         sda_oe  <= 1'b0;
      end else begin
         case (st)
            ST_RX: begin
               if (scl_rise && bit_cnt != 4'h8) begin
                  shreg   <= {shreg[6:0], pin_lvl.sda};
                  bit_cnt <= bit_cnt + 4'h1;
               end else if (byte_done) begin
                  if (kind == K_ADDR && !addr_hit) begin
                     st <= ST_IDLE;                                      // RULE_02
                  end else begin
                     if (kind == K_ADDR) begin
                        rw <= shreg[0];
                     end
                     if (kind == K_INDEX) begin
                        idx <= shreg;                                    // RULE_25
                     end
                     sda_oe <= 1'b1;                                     // RULE_05
                     st     <= ST_RX_ACK;
                  end
               end
            end
            ST_RX_ACK: begin
               // Held low through the ninth clock high phase; after its fall released, or kept low for a 0 first read bit
               if (scl_fall) begin                                       // RULE_06
                  if (load_tx) begin
                     shreg   <= rd_byte(idx);
                     sda_oe  <= ((rd_byte(idx) & 8'h80) == 8'h00);       // RULE_04
                     bit_cnt <= 4'h1;
                     st      <= ST_TX;
                  end else begin
                     sda_oe  <= 1'b0;
                     bit_cnt <= 4'h0;
                     kind    <= (kind == K_ADDR) ? K_INDEX : K_DATA;
                     st      <= ST_RX;
                  end
               end
            end
            ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt == 4'h8) begin
                     sda_oe <= 1'b0;
                     st     <= ST_TX_ACK;
                  end else begin
                     sda_oe  <= ~shreg[6];                               // RULE_04
                     shreg   <= {shreg[6:0], 1'b0};
                     bit_cnt <= bit_cnt + 4'h1;
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  nack_q <= pin_lvl.sda;                                 // RULE_07
               end else if (scl_fall) begin
                  if (nack_q) begin
                     st     <= ST_IDLE;                                  // RULE_08
                     sda_oe <= 1'b0;
                  end else begin
                     shreg   <= rd_byte(idx);
                     sda_oe  <= ((rd_byte(idx) & 8'h80) == 8'h00);
                     bit_cnt <= 4'h1;
                     st      <= ST_TX;
                  end
               end
            end
            default: begin
               st     <= ST_IDLE;
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   assign o_sda_out = 1'b0;
   assign o_sda_oe  = sda_oe;

   // ************************************************************
   // Status, acknowledge and mask registers
   // ************************************************************
   assign rd_set_chg = (load_tx && idx == IDX_CHG_STATUS) ? charge_status : 8'h00;     // RULE_22
   assign rd_set_reg = (load_tx && idx == IDX_REG_STATUS) ? regulator_status : 8'h00;  // RULE_22

   // Edge bits: a new rising edge wins over the acked-and-low clear
   assign next_charge_status = (src.chg & CHG_LEVEL_BITS)                              // RULE_09 RULE_10
                             | (CHG_EDGE_BITS & (src_rise.chg
                                | (charge_status & ~(~src.chg & charge_irq_ack))));     // RULE_23

   assign reg_level = {4'h0,
                       src.regl[3] & src.second_linear_regulator_en,                                        // RULE_15
                       src.regl[2] & src.first_linear_regulator_en,
                       src.regl[1],
                       src.regl[0] | (src.core_lp_sel & src.low_power)};                 // RULE_16

   assign next_regulator_status = reg_level                                             // RULE_14
                                | (REG_EDGE_BITS & (src_rise.regl
                                   | (regulator_status & ~(~src.regl & regulator_irq_ack))));  // RULE_24

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         charge_status    <= STATUS_RESET;
         regulator_status <= STATUS_RESET;
      end else begin
         charge_status    <= next_charge_status;                                        // RULE_12
         regulator_status <= next_regulator_status;
      end
   end

   // Ack tracks the next status so it can never outlive its condition
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         charge_irq_ack    <= ACK_RESET;
         regulator_irq_ack <= ACK_RESET;
      end else begin
         charge_irq_ack    <= (charge_irq_ack | rd_set_chg) & next_charge_status;      // RULE_21
         regulator_irq_ack <= (regulator_irq_ack | rd_set_reg) & next_regulator_status; // RULE_21
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         charge_irq_mask    <= MASK_RESET;                                             // RULE_18
         regulator_irq_mask <= MASK_RESET;                                             // RULE_19
      end else if (wr_stb) begin
         if (idx == IDX_CHG_MASK) begin
            charge_irq_mask <= shreg;
         end
         if (idx == IDX_REG_MASK) begin
            regulator_irq_mask <= shreg;
         end
      end
   end

   // Timer and termination bits follow the charger, so clearing them means restarting it
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_charger_restart <= 1'b0;
      end else begin
         o_charger_restart <= wr_stb && (idx == IDX_CHG_STATUS)
                           && (|(~shreg & charge_status & CHG_WR_BITS));               // RULE_11
      end
   end

   // ************************************************************
   // Interrupt output
   // ************************************************************
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         o_irq_n <= 1'b1;
      end else begin
         o_irq_n <= ~(|(charge_status & ~charge_irq_mask & ~charge_irq_ack)            // RULE_13 RULE_20
                   | |(regulator_status & ~regulator_irq_mask & ~regulator_irq_ack));  // RULE_17
      end
   end

   // ************************************************************
   // Assertions
   // ************************************************************
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_srst);

   ack_drive_a: assert property ((st == ST_RX_ACK) |-> (o_sda_oe && !o_sda_out))  // RULE_05
      else $error("ack slot not driven low");
   ack_hold_a: assert property ((st == ST_RX_ACK && scl_rise) |=> o_sda_oe [*2])  // RULE_05
      else $error("ack released during clock high");
   sda_timing_a: assert property ((o_sda_oe != $past(o_sda_oe)) |->               // RULE_04
                                  ($past(scl_fall) || $past(start_det) || $past(stop_det)))
      else $error("data line moved outside clock low");
   nack_release_a: assert property ((st == ST_TX_ACK && scl_fall && nack_q) |=>   // RULE_08
                                    (st == ST_IDLE && !o_sda_oe))
      else $error("line held after not-acknowledge");
   addr_miss_a: assert property ((byte_done && kind == K_ADDR && !addr_hit) |=>   // RULE_02
                                 (st == ST_IDLE && !o_sda_oe))
      else $error("foreign address acknowledged");
   unmapped_ff_a: assert property ((load_tx && idx > IDX_REG_ACK) |=>           // RULE_03
                                   (shreg == UNMAPPED_BYTE))
      else $error("unmapped read not FFh");
   mask_reset_a: assert property ($fell(i_srst) |->                               // RULE_18
                                  (charge_irq_mask == MASK_RESET && regulator_irq_mask == MASK_RESET))
      else $error("masks not FFh after reset");
   irq_low_a: assert property ((|(charge_status & ~charge_irq_mask & ~charge_irq_ack)) |=> !o_irq_n)  // RULE_13
      else $error("unmasked charge status did not assert interrupt");
   ack_subset_a: assert property (((charge_irq_ack & ~charge_status) == 8'h00)   // RULE_21
                                  && ((regulator_irq_ack & ~regulator_status) == 8'h00))
      else $error("ack bit outlived its status");
   auto_ack_a: assert property ((load_tx && idx == IDX_CHG_STATUS) |=>          // RULE_22
                                ((($past(charge_status) & charge_status) & ~charge_irq_ack) == 8'h00))
      else $error("read did not acknowledge status");
   reg_bit4_a: assert property (regulator_status[4] == 1'b0)                     // RULE_14
      else $error("regulator bit 4 not zero");
   restart_a: assert property ((wr_stb && idx == IDX_CHG_STATUS                   // RULE_11
                                && |(~shreg & charge_status & CHG_WR_BITS)) |=> o_charger_restart)
      else $error("charger restart missing");

   write_c: cover property (wr_stb && idx == IDX_CHG_MASK);
   read_nack_c: cover property (st == ST_TX_ACK && scl_fall && nack_q);
   irq_c: cover property ($fell(o_irq_n));
   auto_ack_c: cover property (load_tx && idx == IDX_REG_STATUS && |regulator_status);

endmodule : pssi_status_irq

/* File: pssi_status_irq_tb.sv */
// Self-checking bench for the serial status and interrupt port.
// Assumes the design package and the bus master model are compiled first.
`timescale 1ns/1ps
module pssi_status_irq_tb;
   import pssi_pkg::*;
   logic       mclk, srst, scl, m_oe, sda_out, sda_oe, irq_n, restart, lsb, sda, ak;
   pssi_src_t  src;
   int         bad_count, n_checks, cyc, n_restart;
   logic [7:0] mdl [8];
   logic [7:0] rx, v;

   // Open-drain data wire with pull-up
   assign sda = !(m_oe || (sda_oe && !sda_out));

   pssi_status_irq uut (.i_mclk(mclk), .i_srst(srst), .i_scl(scl), .i_sda(sda), .i_addr_lsb_select(lsb),
      .i_src(src), .o_sda_out(sda_out), .o_sda_oe(sda_oe), .o_irq_n(irq_n), .o_charger_restart(restart));
   pssi_master mst (.i_mclk(mclk), .i_sda(sda), .o_scl(scl), .o_sda_oe(m_oe));

   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   always @(posedge mclk) begin
      cyc++;
      if (restart === 1'b1) n_restart++;
      if (cyc == 40000) begin
         bad_count++;
         $display("run exceeded its cycle budget");
         end_of_test();
      end
   end

   // ****************************************
   // Model and checking tasks
   // ****************************************
   task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   function automatic logic exp_irq();
      return !(|(mdl[1] & ~mdl[3] & ~mdl[5]) || |(mdl[2] & ~mdl[4] & ~mdl[6]));
   endfunction : exp_irq

   // Edge bits hold until their source is low and acknowledged
   task automatic mupd();
      logic [7:0] lv;
      lv = {4'h0, src.regl[3] & src.second_linear_regulator_en, src.regl[2] & src.first_linear_regulator_en, src.regl[1],
            src.regl[0] | (src.core_lp_sel & src.low_power)};
      mdl[1] = src.chg | (mdl[1] & CHG_EDGE_BITS & (src.chg | ~mdl[5]));
      mdl[2] = lv | (src.regl & REG_EDGE_BITS) | (mdl[2] & REG_EDGE_BITS & (src.regl | ~mdl[6]));
      mdl[5] &= mdl[1];
      mdl[6] &= mdl[2];
   endtask : mupd

   task automatic drv(logic [7:0] c, logic [7:0] r, logic [3:0] e);
      @(posedge mclk);
      src <= {c, r, e};
      repeat (10) @(posedge mclk);
      mupd();
      chk("irq after source", irq_n, exp_irq());
   endtask : drv

   task automatic wr(logic [7:0] idx, logic [7:0] d);
      logic [7:0] b [3];
      b = '{{ADDR_UPPER, lsb, 1'b0}, idx, d};
      mst.start();
      for (int i = 0; i < 3; i++) begin
         mst.xfer(b[i], 1'b1, rx, ak);
         chk("write ack", ak, 0);
      end
      mst.stop();
      if (idx == 8'h03 || idx == 8'h04) mdl[idx[2:0]] = d;
   endtask : wr

   task automatic rd(logic [7:0] idx);
      logic [7:0] exp;
      exp = (idx < 8'h07) ? mdl[idx[2:0]] : UNMAPPED_BYTE;
      wr_index(idx);
      mst.start();
      mst.xfer({ADDR_UPPER, lsb, 1'b1}, 1'b1, rx, ak);
      chk("read addr ack", ak, 0);
      mst.xfer(8'hff, 1'b1, v, ak);
      chk("line released", sda_oe, 0);
      mst.stop();
      chk("read data", v, exp);
      if (idx == 8'h01) mdl[5] |= mdl[1];
      if (idx == 8'h02) mdl[6] |= mdl[2];
      mupd();
      chk("irq after read", irq_n, exp_irq());
   endtask : rd

   // Index phase of a read, ended by a repeated start
   task automatic wr_index(logic [7:0] idx);
      mst.start();
      mst.xfer({ADDR_UPPER, lsb, 1'b0}, 1'b1, rx, ak);
      mst.xfer(idx, 1'b1, rx, ak);
      chk("index ack", ak, 0);
   endtask : wr_index

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_of_test

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      srst = 1'b1;
      src = '0;
      bad_count = 0;
      n_checks = 0;
      cyc = 0;
      n_restart = 0;
      v = $urandom(41);
      lsb = v[0];
      mdl = '{8'hff, 8'h00, 8'h00, 8'hff, 8'hff, 8'h00, 8'h00, 8'hff};
      repeat (20) @(posedge mclk);
      srst <= 1'b0;
      repeat (6) @(posedge mclk);
      chk("irq at reset", irq_n, 1);
      for (int i = 0; i < 8; i++) rd(8'(i));
      $display("test reset values done");

      for (int i = 0; i < 2; i++) begin
         mst.start();
         mst.xfer(i ? {ADDR_UPPER ^ 6'h01, lsb, 1'b0} : {ADDR_UPPER, ~lsb, 1'b0}, 1'b1, rx, ak);
         chk("foreign address ack", ak, 1);
         mst.stop();
      end
      $display("test addressing done");

      mdl[3] = 8'($urandom);
      mdl[4] = 8'($urandom);
      wr(8'h03, mdl[3]);
      wr(8'h04, mdl[4]);
      for (int i = 2; i < 7; i++) wr(8'(i), (i == 3 || i == 4) ? mdl[i] : 8'hff);
      for (int i = 2; i < 7; i++) rd(8'(i));
      rd(8'h20);
      wr_index(8'h03);
      mst.start();
      mst.xfer({ADDR_UPPER, lsb, 1'b1}, 1'b1, rx, ak);
      mst.xfer(8'hff, 1'b0, v, ak);
      chk("first of two reads", v, mdl[3]);
      mst.xfer(8'hff, 1'b1, v, ak);
      chk("second of two reads", v, mdl[3]);
      mst.stop();
      $display("test register access done");

      wr(8'h03, 8'h00);
      wr(8'h04, 8'h00);
      mdl[3] = 8'h00;
      mdl[4] = 8'h00;
      drv(8'h80, 8'h00, 4'h0);
      rd(8'h01);
      rd(8'h05);
      drv(8'h01, 8'h00, 4'h0);
      drv(8'h00, 8'h00, 4'h0);
      rd(8'h01);
      rd(8'h01);
      rd(8'h05);
      $display("test charge status done");

      drv(8'h84, 8'h00, 4'h0);
      n_restart = 0;
      wr(8'h01, 8'h00);
      repeat (4) @(posedge mclk);
      chk("restart pulses", 8'(n_restart), 1);
      rd(8'h01);
      drv(8'h00, 8'h00, 4'h0);
      $display("test charger restart done");

      drv(8'h00, 8'h1f, 4'b1000);
      rd(8'h02);
      rd(8'h06);
      drv(8'h00, 8'h00, 4'h0);
      drv(8'h00, 8'h80, 4'b0011);
      drv(8'h00, 8'h00, 4'b0011);
      rd(8'h02);
      rd(8'h06);
      $display("test regulator status done");
      end_of_test();
   end
endmodule : pssi_status_irq_tb

/* File: pssi_sync.sv */
// Two-flop synchroniser with edge detection for a bundle of pin inputs.
// Assumes the inputs are asynchronous to i_mclk; edges come from flops two and three.
`timescale 1ns/1ps
module pssi_sync #(
   parameter int W = 1
) (
   input  wire logic         i_mclk,
   input  wire logic         i_srst,
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_level,
   output logic      [W-1:0] o_rise,
   output logic      [W-1:0] o_fall
);

   logic [W-1:0] meta;
   logic [W-1:0] stab;
   logic [W-1:0] prev;

   // First stage is read only by the second stage
   always_ff @(posedge i_mclk) begin
      if (i_srst) begin
         meta <= '0;
         stab <= '0;
         prev <= '0;
      end else begin
         meta <= i_async;
         stab <= meta;
         prev <= stab;
      end
   end

   assign o_level = stab;
   assign o_rise  = stab & ~prev;
   assign o_fall  = ~stab & prev;

endmodule : pssi_sync
